// File: verilog/gdr_cfg.svh
/*
 * Offsets, field positions, masks, reset values and timing counts of the
 * gate driver register bank. Definitions only; included by bare name.
 */
`ifndef GDR_CFG_SVH
`define GDR_CFG_SVH

`define GDR_A_WARN        4'h1
`define GDR_A_OC          4'h2
`define GDR_A_CHIP        4'h3
`define GDR_A_GATE        4'h4
`define GDR_A_HS          4'h5
`define GDR_A_LS          4'h6
`define GDR_A_TIMING      4'h7
`define GDR_A_RSVD        4'h8
`define GDR_A_OP          4'h9
`define GDR_A_AMP         4'hA
`define GDR_A_VREG        4'hB
`define GDR_A_VDS         4'hC

`define GDR_M_HS          11'h3FF
`define GDR_M_LS          11'h3FF
`define GDR_M_TIMING      11'h3FF
`define GDR_M_OP          11'h7FF
`define GDR_M_AMP         11'h7FF
`define GDR_M_VREG        11'h31F
`define GDR_M_VDS         11'h0FF
`define GDR_M_WARN_LIVE   11'h1DF
`define GDR_M_OC          11'h7E7
`define GDR_M_OC_VDS      11'h7E0
`define GDR_M_OC_SENSE    11'h007
`define GDR_M_CHIP        11'h577
`define GDR_M_GATE        11'h7E0

`define GDR_D_HS          11'h344
`define GDR_D_LS          11'h344
`define GDR_D_TIMING      11'h000
`define GDR_D_OP          11'h000
`define GDR_D_AMP         11'h000
`define GDR_D_VREG        11'h000
`define GDR_D_VDS         11'h000

`define GDR_B_FAULT       10
`define GDR_B_TEMP_TOP    8
`define GDR_B_LIVE_OC     5
`define GDR_B_TEMP_LOW    3
`define GDR_B_LOCKOUT     10
`define GDR_B_WD_EXPIRED  9
`define GDR_B_OVERHEAT_SD 8
`define GDR_B_FLIP_OVH    10
`define GDR_B_DIS_LOCKOUT 9
`define GDR_B_DIS_GATE    8
`define GDR_B_WD_DLY_HI   6
`define GDR_B_WD_DLY_LO   5
`define GDR_B_DIS_SENSE   4
`define GDR_B_WD_EN       3
`define GDR_B_SLEEP       2
`define GDR_B_CLR         1

`define GDR_CNT_ADDR      5'h04
`define GDR_CNT_DATA      5'h05
`define GDR_CNT_LAST      5'h0F
`define GDR_CNT_OVER      5'h11

`define GDR_CLK_MHZ       100
`define GDR_WD_BASE_US    1000

`endif

// File: verilog/gdr_pkg.sv
/*
 * Types shared by the gate driver register bank and its serial link.
 * Assumes the constants of gdr_cfg.svh for values.
 */
package gdr_pkg;
    typedef logic [10:0] gdr_word_t;

    typedef struct packed {
        logic      rd;
        logic [3:0] addr;
        gdr_word_t data;
    } gdr_frame_t;
endpackage

// File: verilog/gdr_link_if.sv
/*
 * Carrier between the serial link (serial clock domain) and the register
 * core (system clock domain). Frame, ok flag and address are quasi-static
 * words qualified by the synchronised levels addr_rdy, frame_tgl and nscs.
 */
`timescale 1ns/1ps
interface gdr_link_if;
    gdr_pkg::gdr_frame_t frame;
    logic                ok;
    logic                frame_tgl;
    logic [3:0]          addr;
    logic                addr_rdy;
    gdr_pkg::gdr_word_t  rd_data;

    modport link (output frame, output ok, output frame_tgl, output addr,
                  output addr_rdy, input rd_data);
    modport core (input frame, input ok, input frame_tgl, input addr,
                  input addr_rdy, output rd_data);
endinterface

// File: verilog/gdr_sync.sv
/*
 * Two-flop synchroniser, one pair per bit.
 * Assumes each bit is a level that stays put for several clk cycles.
 */
`timescale 1ns/1ps
module gdr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    meta_q <= 1'b0;
                    q[i]   <= 1'b0;
                end else begin
                    meta_q <= d[i];
                    q[i]   <= meta_q;
                end
            end
        end
    endgenerate
endmodule

// File: verilog/gdr_spi_link.sv
/*
 * Serial slave, mode CPOL=0 CPHA=1: capture on falling sclk, shift out on
 * rising sclk, MSB first. Assumes sclk is low when nscs moves and that the
 * core has the read word ready within half an sclk period of bit five.
 */
`timescale 1ns/1ps
`include "gdr_cfg.svh"
module gdr_spi_link (
    input  wire logic  sclk,
    input  wire logic  nrst,
    input  wire logic  nscs,
    input  wire logic  sdi,
    output logic       sdo,
    output logic       sdo_oe_n,
    gdr_link_if.link   lnk
);
    import gdr_pkg::*;

    logic [4:0]  cnt_q;
    logic [15:0] sh_q;
    logic        ok_q;
    logic        tgl_q;
    logic [3:0]  addr_q;
    logic        addr_rdy_q;
    gdr_word_t   out_q;

    // Bit counter, cleared by the frame's own select
    always_ff @(negedge sclk or posedge nscs or negedge nrst) begin
        if (!nrst || nscs) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != `GDR_CNT_OVER) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    always_ff @(negedge sclk or negedge nrst) begin
        if (!nrst) begin
            sh_q   <= 16'h0000;
            ok_q   <= 1'b0;
            tgl_q  <= 1'b0;
            addr_q <= 4'h0;
        end else begin
            sh_q <= {sh_q[14:0], sdi};
            ok_q <= (cnt_q == `GDR_CNT_LAST);
            if (cnt_q == `GDR_CNT_LAST) begin
                tgl_q <= ~tgl_q;
            end
            if (cnt_q == `GDR_CNT_ADDR) begin
                addr_q <= {sh_q[2:0], sdi};
            end
        end
    end

    always_ff @(negedge sclk or posedge nscs or negedge nrst) begin
        if (!nrst || nscs) begin
            addr_rdy_q <= 1'b0;
        end else if (cnt_q == `GDR_CNT_ADDR) begin
            addr_rdy_q <= 1'b1;
        end
    end

    always_ff @(posedge sclk or posedge nscs or negedge nrst) begin
        if (!nrst || nscs) begin
            sdo      <= 1'b0;
            sdo_oe_n <= 1'b1;
            out_q    <= 11'h000;
        end else begin
            sdo_oe_n <= 1'b0;
            if (cnt_q == `GDR_CNT_DATA) begin
                sdo   <= lnk.rd_data[10];
                out_q <= {lnk.rd_data[9:0], 1'b0};
            end else if (cnt_q > `GDR_CNT_DATA) begin
                sdo   <= out_q[10];
                out_q <= {out_q[9:0], 1'b0};
            end else begin
                sdo <= 1'b0;
            end
        end
    end

    assign lnk.frame     = sh_q;
    assign lnk.ok        = ok_q;
    assign lnk.frame_tgl = tgl_q;
    assign lnk.addr      = addr_q;
    assign lnk.addr_rdy  = addr_rdy_q;

    a_frame_len_ok : assert property (@(negedge sclk) disable iff (!nrst || nscs)
        (cnt_q == `GDR_CNT_LAST) |=> ok_q ##1 !ok_q)
        else $error("frame length flag wrong");
endmodule

// File: verilog/gdr_regs.sv
/*
 * Register bank of a three-phase gate driver: status flags, fault latches,
 * watchdog and read/write control registers behind a four-wire serial port.
 * Assumes monitor inputs and en_gate are asynchronous levels, nrst is the
 * power-up reset, and the serial master keeps nscs high between frames.
 */
`timescale 1ns/1ps
`include "gdr_cfg.svh"

// Notes on behaviour
// - Addresses one to four are read-only; writes there change no register bit.
// - Warning bits 3, 2, 1, 8 show the four die temperature thresholds.
// - Warning bit five is the live unlatched OR of drain-source monitors.
// - Warning bit seven is supply undervoltage, bit six supply overvoltage.
// - Warning bit four is charge-pump undervoltage warning.
// - Register two bits ten to five hold per-transistor drain-source faults.
// - Register two bits two to zero hold sense faults C, B, A.
// - Register three bit ten is supply lockout, bit eight overheat shutdown.
// - Reading or writing register one restarts the watchdog; expiry sets bit nine.
// - Register three bits two to zero hold high-side pump faults.
// - Register three bits six to four hold regulator, analog, low gate faults.
// - Register four bits ten to five hold gate-source voltage faults.
// - Control registers are read/write and return the last written value ANDed with their mask.
// - Reads, fault clearing and enable pin never reset control registers.
// - Power-up loads every control register with its default.
// - Entering sleep loads every control register with its default.
// - Eleven-bit registers at one to twelve, eight reserved, status zero at reset.
// - Sixteen-bit frame: read flag, four address bits, eleven data bits.
module gdr_regs #(
    parameter int WD_BASE_CYC = `GDR_WD_BASE_US * `GDR_CLK_MHZ
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          sclk,
    input  wire logic          nscs,
    input  wire logic          sdi,
    output logic               sdo,
    output logic               sdo_oe_n,
    input  wire logic          en_gate,
    input  wire gdr_pkg::gdr_word_t warn_mon,
    input  wire gdr_pkg::gdr_word_t oc_mon,
    input  wire gdr_pkg::gdr_word_t chip_mon,
    input  wire gdr_pkg::gdr_word_t gate_mon,
    output gdr_pkg::gdr_word_t ctl_hs,
    output gdr_pkg::gdr_word_t ctl_ls,
    output gdr_pkg::gdr_word_t ctl_timing,
    output gdr_pkg::gdr_word_t ctl_op,
    output gdr_pkg::gdr_word_t ctl_amp,
    output gdr_pkg::gdr_word_t ctl_vreg,
    output gdr_pkg::gdr_word_t ctl_vds,
    output logic               fault_out,
    output logic               sleep_req
);
    import gdr_pkg::*;

    localparam int SYNC_W = 48;

    gdr_link_if lk ();

    logic [SYNC_W-1:0] sync_d;
    logic [SYNC_W-1:0] sync_q;
    gdr_word_t         warn_s;
    gdr_word_t         oc_s;
    gdr_word_t         chip_s;
    gdr_word_t         gate_s;
    logic              en_gate_s;
    logic              cs_s;
    logic              ar_s;
    logic              tgl_s;
    logic              cs_q;
    logic              ar_q;
    logic              tgl_seen_q;
    gdr_frame_t        frm;
    logic              frame_take;
    logic              wr_go;
    logic              op_wr;
    logic              clr_go;
    logic              sleep_go;
    logic              kick;
    logic [12:5][10:0] cfg;
    gdr_word_t         st_warn;
    gdr_word_t         f2_q;
    gdr_word_t         f3_q;
    gdr_word_t         f4_q;
    gdr_word_t         f2_set;
    gdr_word_t         f3_set;
    gdr_word_t         f4_set;
    logic              fault_any;
    gdr_word_t         rd_word;
    gdr_word_t         rdata_q;
    logic [23:0]       wd_cnt_q;
    logic [23:0]       wd_lim;
    logic              wd_en;
    logic              wd_hit;

    gdr_spi_link u_link (
        .sclk     (sclk),
        .nrst     (nrst),
        .nscs     (nscs),
        .sdi      (sdi),
        .sdo      (sdo),
        .sdo_oe_n (sdo_oe_n),
        .lnk      (lk.link)
    );

    assign sync_d = {warn_mon, oc_mon, chip_mon, gate_mon,
                     en_gate, nscs, lk.addr_rdy, lk.frame_tgl};

    gdr_sync #(.W(SYNC_W)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (sync_d),
        .q    (sync_q)
    );

    assign {warn_s, oc_s, chip_s, gate_s, en_gate_s, cs_s, ar_s, tgl_s} = sync_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_q       <= 1'b0;
            ar_q       <= 1'b0;
            tgl_seen_q <= 1'b0;
        end else begin
            cs_q <= cs_s;
            ar_q <= ar_s;
            if (cs_s && !cs_q) begin
                tgl_seen_q <= tgl_s;
            end
        end
    end

    // Frame word is still in the link; sclk idles once nscs is high.
    // A fresh toggle rejects empty frames, ok rejects short and long ones.
    assign frm        = lk.frame;
    assign frame_take = cs_s && !cs_q && lk.ok && (tgl_s != tgl_seen_q);
    assign wr_go      = frame_take && !frm.rd;
    assign op_wr      = wr_go && (frm.addr == `GDR_A_OP);
    assign clr_go     = op_wr && frm.data[`GDR_B_CLR];
    // Sleep is only honoured with the gate enable low
    assign sleep_go   = op_wr && frm.data[`GDR_B_SLEEP] && !en_gate_s;
    // any access of the warning register
    assign kick       = frame_take && (frm.addr == `GDR_A_WARN);

    function automatic gdr_word_t cfg_mask(input int idx);
        case (idx)
            5:       cfg_mask = `GDR_M_HS;
            6:       cfg_mask = `GDR_M_LS;
            7:       cfg_mask = `GDR_M_TIMING;
            9:       cfg_mask = `GDR_M_OP;
            10:      cfg_mask = `GDR_M_AMP;
            11:      cfg_mask = `GDR_M_VREG;
            12:      cfg_mask = `GDR_M_VDS;
            default: cfg_mask = 11'h000;
        endcase
    endfunction

    function automatic gdr_word_t cfg_dflt(input int idx);
        case (idx)
            5:       cfg_dflt = `GDR_D_HS;
            6:       cfg_dflt = `GDR_D_LS;
            7:       cfg_dflt = `GDR_D_TIMING;
            9:       cfg_dflt = `GDR_D_OP;
            10:      cfg_dflt = `GDR_D_AMP;
            11:      cfg_dflt = `GDR_D_VREG;
            12:      cfg_dflt = `GDR_D_VDS;
            default: cfg_dflt = 11'h000;
        endcase
    endfunction

    genvar gi;
    generate
        for (gi = 5; gi <= 12; gi++) begin : g_cfg
            if (gi == 8) begin : g_rsvd
                assign cfg[gi] = 11'h000;
            end else begin : g_reg
                gdr_word_t q;
                // power-up default; sleep reloads the same default
                always_ff @(posedge clk or negedge nrst) begin
                    if (!nrst) begin
                        q <= cfg_dflt(gi);
                    end else if (sleep_go) begin
                        q <= cfg_dflt(gi);
                    // write lands; status owns no slot; masks
                    end else if (wr_go && (frm.addr == 4'(gi))) begin
                        q <= frm.data & cfg_mask(gi);
                    end
                end
                assign cfg[gi] = q;
            end
        end
    endgenerate

    assign wd_en = cfg[9][`GDR_B_WD_EN];

    // disabled monitors neither latch nor report
    always_comb begin
        f2_set = oc_s & `GDR_M_OC;
        if (cfg[9][`GDR_B_DIS_SENSE]) begin
            f2_set = f2_set & ~`GDR_M_OC_SENSE;
        end
        f3_set = chip_s & `GDR_M_CHIP;
        f3_set[`GDR_B_LOCKOUT]     = f3_set[`GDR_B_LOCKOUT] && !cfg[9][`GDR_B_DIS_LOCKOUT];
        f3_set[`GDR_B_OVERHEAT_SD] = f3_set[`GDR_B_OVERHEAT_SD] && !cfg[9][`GDR_B_FLIP_OVH];
        f3_set[`GDR_B_WD_EXPIRED]  = wd_hit;
        f4_set = cfg[9][`GDR_B_DIS_GATE] ? 11'h000 : (gate_s & `GDR_M_GATE);
    end

    // drain-source latches; sense latches; set beats clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            f2_q <= 11'h000;
        end else begin
            f2_q <= (clr_go ? 11'h000 : f2_q) | f2_set;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            f3_q <= 11'h000;
        end else begin
            f3_q <= (clr_go ? 11'h000 : f3_q) | f3_set;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            f4_q <= 11'h000;
        end else begin
            f4_q <= (clr_go ? 11'h000 : f4_q) | f4_set;
        end
    end

    assign fault_any = |{f2_q, f3_q, f4_q};

    always_comb begin
        st_warn = warn_s & `GDR_M_WARN_LIVE;
        st_warn[`GDR_B_LIVE_OC] = |(oc_s & `GDR_M_OC_VDS);
        st_warn[`GDR_B_FAULT]   = fault_any;
    end

    // watchdog counter, limit doubles per delay step
    assign wd_lim = 24'(WD_BASE_CYC) << cfg[9][`GDR_B_WD_DLY_HI:`GDR_B_WD_DLY_LO];
    assign wd_hit = wd_en && !kick && (wd_cnt_q == wd_lim - 24'h00_0001);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wd_cnt_q <= 24'h00_0000;
        end else if (!wd_en || kick || wd_hit) begin
            wd_cnt_q <= 24'h00_0000;
        end else begin
            wd_cnt_q <= wd_cnt_q + 24'h00_0001;
        end
    end

    // map; reserved and unmapped read zero
    always_comb begin
        case (lk.addr)
            `GDR_A_WARN:   rd_word = st_warn;
            `GDR_A_OC:     rd_word = f2_q;
            `GDR_A_CHIP:   rd_word = f3_q;
            `GDR_A_GATE:   rd_word = f4_q;
            `GDR_A_HS:     rd_word = cfg[5];
            `GDR_A_LS:     rd_word = cfg[6];
            `GDR_A_TIMING: rd_word = cfg[7];
            `GDR_A_OP:     rd_word = cfg[9];
            `GDR_A_AMP:    rd_word = cfg[10];
            `GDR_A_VREG:   rd_word = cfg[11];
            `GDR_A_VDS:    rd_word = cfg[12];
            default:       rd_word = 11'h000;
        endcase
    end

    // Sampled once per frame; link shifts it from bit six onward
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 11'h000;
        end else if (ar_s && !ar_q) begin
            rdata_q <= rd_word;
        end
    end

    assign lk.rd_data = rdata_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fault_out <= 1'b0;
            sleep_req <= 1'b0;
        end else begin
            fault_out <= fault_any;
            sleep_req <= sleep_go;
        end
    end

    assign ctl_hs     = cfg[5];
    assign ctl_ls     = cfg[6];
    assign ctl_timing = cfg[7];
    assign ctl_op     = cfg[9];
    assign ctl_amp    = cfg[10];
    assign ctl_vreg   = cfg[11];
    assign ctl_vds    = cfg[12];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_wr(logic [3:0] a);
        wr_go && (frm.addr == a);
    endsequence

    sequence s_status_wr;
        wr_go && (frm.addr >= `GDR_A_WARN) && (frm.addr <= `GDR_A_GATE);
    endsequence

    a_status_ro_cfg : assert property (s_status_wr |=> $stable(cfg))
        else $error("status write touched control");

    a_live_oc_or : assert property (
        $rose(|(oc_s & `GDR_M_OC_VDS)) |-> st_warn[`GDR_B_LIVE_OC] ##1
        (st_warn[`GDR_B_LIVE_OC] == |(oc_s & `GDR_M_OC_VDS)))
        else $error("live overcurrent bit wrong");

    a_temp_follow : assert property (
        $fell(warn_s[`GDR_B_TEMP_TOP]) |-> !st_warn[`GDR_B_TEMP_TOP])
        else $error("temperature flag latched");

    a_fault_sticky : assert property (
        (f2_q[10] && !clr_go) |=> f2_q[10] && fault_out)
        else $error("fault bit dropped without clear");

    a_fault_clear : assert property (
        (clr_go && !oc_s[10]) |=> !f2_q[10])
        else $error("clear did not drop fault");

    a_ctl_write : assert property (
        (s_wr(`GDR_A_HS) and !sleep_go) |=> cfg[5] == ($past(frm.data) & `GDR_M_HS))
        else $error("control write lost");

    a_vreg_rsvd : assert property (
        s_wr(`GDR_A_VREG) |=> (cfg[11] & ~`GDR_M_VREG) == 11'h000 ##1 $stable(cfg[11]))
        else $error("reserved bits stored");

    a_clear_keeps : assert property (
        (clr_go && !sleep_go) |=> $stable(cfg[5]) && $stable(cfg[12]))
        else $error("clear disturbed control");

    a_sleep_dflt : assert property (
        sleep_go |=> cfg[5] == `GDR_D_HS && cfg[9] == `GDR_D_OP && sleep_req)
        else $error("sleep did not restore defaults");

    a_wd_kick : assert property (kick |=> wd_cnt_q == 24'h00_0000)
        else $error("watchdog not restarted");

    a_wd_expire : assert property (
        wd_hit |=> f3_q[`GDR_B_WD_EXPIRED] && wd_cnt_q == 24'h00_0000)
        else $error("watchdog expiry not flagged");

    a_rsvd_read : assert property (
        ($rose(ar_s) && lk.addr == `GDR_A_RSVD) |=> rdata_q == 11'h000)
        else $error("reserved address read nonzero");
endmodule

// File: bench/gdr_spi_host.sv
/*
 * Serial host model: drives frames of a caller-given bit count, CPOL=0 CPHA=1, MSB first.
 * Assumes the slave shifts sdo on rising sclk and samples on falling sclk.
 */
`timescale 1ns/1ps
module gdr_spi_host (
    output logic      sclk,
    output logic      nscs,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        nscs = 1'b1;
        sdi  = 1'b0;
    end

    task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
        r    = 16'h0000;
        nscs = 1'b0;
        for (int i = 0; i < n; i++) begin
            #80 sclk = 1'b1;
            sdi  = w[15-i];
            #80 sclk = 1'b0;
            r    = {r[14:0], sdo};
        end
        #80 nscs = 1'b1;
        // Idle sdi flips, so a stale bit never passes for data
        sdi  = ~sdi;
        #600;
    endtask
endmodule

// File: bench/gdr_regs_bench.sv
/*
 * Self-checking bench of the gate driver register bank.
 * Assumes gdr_spi_host drives the serial port at a 160 ns sclk period.
 */
`timescale 1ns/1ps
`include "gdr_cfg.svh"
module gdr_regs_bench;
    import gdr_pkg::*;
    localparam logic [3:0] CA [7] = '{`GDR_A_HS, `GDR_A_LS, `GDR_A_TIMING, `GDR_A_OP,
                                      `GDR_A_AMP, `GDR_A_VREG, `GDR_A_VDS};
    localparam gdr_word_t  CM [7] = '{`GDR_M_HS, `GDR_M_LS, `GDR_M_TIMING, `GDR_M_OP,
                                      `GDR_M_AMP, `GDR_M_VREG, `GDR_M_VDS};
    localparam gdr_word_t  CD [7] = '{`GDR_D_HS, `GDR_D_LS, `GDR_D_TIMING, `GDR_D_OP,
                                      `GDR_D_AMP, `GDR_D_VREG, `GDR_D_VDS};
    logic        clk, nrst, en_gate, sclk, nscs, sdi, sdo, sdo_oe_n, fault_out, sleep_req;
    gdr_word_t   warn_mon, oc_mon, chip_mon, gate_mon, ctl_hs, ctl_op;
    logic [15:0] resp;
    int          bad_count, samples_checked, sleep_pulses;

    // Released pin reads inverted, so a stale level never passes for data
    gdr_spi_host host (.sclk(sclk), .nscs(nscs), .sdi(sdi), .sdo(sdo ^ sdo_oe_n));
    // Short base so a frame-spaced kick still lands in time
    gdr_regs #(.WD_BASE_CYC(400)) uut (
        .clk(clk), .nrst(nrst), .sclk(sclk), .nscs(nscs), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .en_gate(en_gate), .warn_mon(warn_mon), .oc_mon(oc_mon),
        .chip_mon(chip_mon), .gate_mon(gate_mon), .ctl_hs(ctl_hs), .ctl_ls(),
        .ctl_timing(), .ctl_op(ctl_op), .ctl_amp(), .ctl_vreg(), .ctl_vds(),
        .fault_out(fault_out), .sleep_req(sleep_req));

    always #5 clk = ~clk;

    // Off the launching edge, so the pulse is counted exactly once
    always @(negedge clk) begin
        if (sleep_req === 1'b1) sleep_pulses++;
    end

    task automatic chk(input string what, input gdr_word_t exp, input gdr_word_t got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [3:0] a, input gdr_word_t exp);
        host.xfer(16, {1'b1, a, 11'h000}, resp);
        chk($sformatf("reg %h", a), exp, resp[10:0]);
    endtask

    task automatic wr(input logic [3:0] a, input gdr_word_t d);
        host.xfer(16, {1'b0, a, d}, resp);
    endtask

    task automatic mon(input gdr_word_t v);
        @(posedge clk);
        #1;
        warn_mon = v;
        oc_mon   = v;
        chip_mon = v;
        gate_mon = v;
        repeat (6) @(posedge clk);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #400000;
        bad_count++;
        $display("[ERR] run end expected done seen timeout");
        end_of_test();
    end

    initial begin
        clk      = 1'b0;
        nrst     = 1'b0;
        en_gate  = 1'b1;
        warn_mon = 11'h000;
        oc_mon   = 11'h000;
        chip_mon = 11'h000;
        gate_mon = 11'h000;
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge clk);
        chk("sdo_oe_n idle", 11'h001, {10'h000, sdo_oe_n});
        for (int i = 1; i <= 4; i++) rd(4'(i), 11'h000);
        for (int i = 0; i < 7; i++) rd(CA[i], CD[i]);
        $display("test reset values done");

        for (int i = 0; i < 7; i++) wr(CA[i], 11'h7F3);
        wr(`GDR_A_RSVD, 11'h7FF);
        wr(`GDR_A_OC, 11'h7FF);
        for (int i = 0; i < 7; i++) rd(CA[i], 11'h7F3 & CM[i]);
        rd(`GDR_A_RSVD, 11'h000);
        rd(`GDR_A_OC, 11'h000);
        host.xfer(15, {1'b0, `GDR_A_HS, 11'h155}, resp);
        rd(`GDR_A_HS, 11'h7F3 & `GDR_M_HS);
        wr(`GDR_A_OP, 11'h000);
        $display("test read write done");

        mon(11'h7FF);
        rd(`GDR_A_WARN, 11'h5FF);
        rd(`GDR_A_OC, 11'h7E7);
        rd(`GDR_A_CHIP, 11'h577);
        rd(`GDR_A_GATE, 11'h7E0);
        chk("fault_out", 11'h001, {10'h000, fault_out});
        mon(11'h000);
        rd(`GDR_A_WARN, 11'h400);
        rd(`GDR_A_CHIP, 11'h577);
        wr(`GDR_A_OP, 11'h002);
        rd(`GDR_A_OC, 11'h000);
        rd(`GDR_A_WARN, 11'h000);
        wr(`GDR_A_OP, 11'h710);
        mon(11'h7FF);
        rd(`GDR_A_OC, 11'h7E0);
        rd(`GDR_A_CHIP, 11'h077);
        rd(`GDR_A_GATE, 11'h000);
        mon(11'h000);
        wr(`GDR_A_OP, 11'h002);
        rd(`GDR_A_OC, 11'h000);
        rd(`GDR_A_HS, 11'h7F3 & `GDR_M_HS);
        $display("test status flags done");

        wr(`GDR_A_OP, 11'h008);
        chk("ctl_op", 11'h008, ctl_op);
        repeat (3) rd(`GDR_A_WARN, 11'h000);
        rd(`GDR_A_CHIP, 11'h000);
        #5000;
        rd(`GDR_A_CHIP, 11'h200);
        wr(`GDR_A_OP, 11'h002);
        rd(`GDR_A_CHIP, 11'h000);
        $display("test watchdog done");

        wr(`GDR_A_OP, 11'h004);
        rd(`GDR_A_OP, 11'h004);
        chk("sleep early", 11'h000, 11'(sleep_pulses));
        @(posedge clk);
        #1 en_gate = 1'b0;
        repeat (4) @(posedge clk);
        chk("ctl_hs kept", 11'h7F3 & `GDR_M_HS, ctl_hs);
        wr(`GDR_A_OP, 11'h004);
        chk("ctl_hs default", `GDR_D_HS, ctl_hs);
        rd(`GDR_A_OP, 11'h000);
        chk("sleep pulses", 11'h001, 11'(sleep_pulses));
        $display("test sleep done");
        end_of_test();
    end
endmodule
